/* shared/special_output_pkg.sv */
// Shared constants and types for the special output port.
// Assumes a 4-bit CPU I/O-memory access port and a 40 MHz core clock.
package special_output_pkg;

   // Register addresses in I/O memory
   localparam logic [7:0] OUTPUT_PORT_CONTROL_ADDR   = 8'hF3;
   localparam logic [7:0] TONE_FREQUENCY_SELECT_ADDR = 8'hFD;

   // Field positions
   localparam int OUT_PIN_ZERO_BIT     = 0;
   localparam int OUT_PIN_ONE_BIT      = 1;
   localparam int DIVCLK_SELECT_LO_BIT = 0;
   localparam int DIVCLK_SELECT_HI_BIT = 1;
   localparam int TONE_PITCH_BIT       = 3;

   // Values after reset
   localparam logic [1:0] OUT_PORT_RESET   = 2'h0;
   localparam logic       TONE_PITCH_RESET = 1'h0;
   localparam logic [1:0] DIVCLK_SEL_RESET = 2'h0;
   localparam logic [3:0] READ_DATA_RESET  = 4'h0;
   localparam logic       PIN_RESET        = 1'h0;

   // Timing: core clock and the oscillator it stands in for
   localparam longint CORE_CLK_HZ = 40000000;
   localparam longint FOSC_HZ     = 32768;
   localparam int     NCO_WIDTH   = 32;
   // Phase step giving two overflows per oscillator period
   localparam logic [NCO_WIDTH-1:0] NCO_STEP =
      NCO_WIDTH'((2 * FOSC_HZ * (64'h1 << NCO_WIDTH)) / CORE_CLK_HZ);

   // Binary divider: tap m carries fosc/2^m
   localparam int DIV_WIDTH    = 8;
   localparam int TONE_TAP_4K  = 3;
   localparam int TONE_TAP_2K  = 4;
   localparam int SET_TAP_BASE = 8;
   localparam int SET_MIN      = 1;
   localparam int SET_MAX      = 5;

   // Special function of the first pin
   typedef enum logic [2:0] {
      PIN0_PLAIN     = 3'h1,
      PIN0_DIVCLK    = 3'h2,
      PIN0_TONE_INV  = 3'h4
   } pin0_mode_t;

   // CPU side access to I/O memory
   typedef struct packed {
      logic [7:0] addr;
      logic       wr;
      logic       rd;
      logic [3:0] wdata;
   } io_req_t;

   // Stored register fields and registered outputs
   typedef struct packed {
      logic [1:0] out_port;
      logic       tone_pitch_select;
      logic [1:0] divclk_select;
      logic [3:0] rdata;
      logic       out_pin_zero;
      logic       out_pin_one;
   } port_state_t;

   // Divider state
   typedef struct packed {
      logic [NCO_WIDTH-1:0] phase;
      logic [DIV_WIDTH-1:0] count;
   } div_state_t;

endpackage

/* logic/tone_divider.sv */
// Free-running binary divider of the oscillator frequency.
// Assumes one core clock; the oscillator is synthesised by a phase accumulator.
`timescale 1ns/1ps
`default_nettype none

module tone_divider
(
   input  wire logic                                     i_core_clk, // Core clock
   input  wire logic                                     i_rst_n,    // Sync reset, low
   output logic [special_output_pkg::DIV_WIDTH-1:0]      o_taps      // Tap m = fosc/2^m
);

   special_output_pkg::div_state_t s_q;
   special_output_pkg::div_state_t s_d;
   logic [special_output_pkg::NCO_WIDTH:0] sum;

   always_comb
   begin
      s_d = s_q;
      sum = {1'b0, s_q.phase} + {1'b0, special_output_pkg::NCO_STEP};
      s_d.phase = sum[special_output_pkg::NCO_WIDTH-1:0];
      // Each overflow is half an oscillator period, so bit 0 toggles at fosc
      if (sum[special_output_pkg::NCO_WIDTH])
      begin
         s_d.count = s_q.count + 1'b1;
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_taps = s_q.count;

endmodule

`default_nettype wire

/* logic/special_output_port.sv */
// Two-bit output port with buzzer and divided-clock special functions.
// Assumes the CPU drives a one-cycle write or read strobe with address and data.
`timescale 1ns/1ps
`default_nettype none

module special_output_port
#(
   // Build choices are fixed at elaboration; no software bit can alter them
   parameter logic                           PIN1_SPECIAL = 1'b0,
   parameter special_output_pkg::pin0_mode_t PIN0_MODE    = special_output_pkg::PIN0_PLAIN,
   parameter int                             DIV_SET      = 1
)
(
   input  wire logic       i_core_clk,    // Core clock, 40 MHz
   input  wire logic       i_rst_n,       // Sync reset, active low
   input  wire logic [7:0] i_addr,        // I/O memory address
   input  wire logic       i_wr,          // Write strobe
   input  wire logic       i_rd,          // Read strobe
   input  wire logic [3:0] i_wdata,       // Write data
   output logic      [3:0] o_rdata,       // Read data, one cycle after strobe
   output logic            o_out_pin_zero, // First output pin
   output logic            o_out_pin_one   // Second output pin
);

   special_output_pkg::port_state_t s_q;
   special_output_pkg::port_state_t s_d;
   special_output_pkg::io_req_t     req;
   logic [special_output_pkg::DIV_WIDTH-1:0] taps;
   logic                            tone;
   logic                            divclk;

   // Divisor tap for a frequency choice under the selected set
   function automatic int divclk_tap(input logic [1:0] sel);
      divclk_tap = special_output_pkg::SET_TAP_BASE - DIV_SET - int'(sel);
   endfunction

   // Read image of a register, unused bits as zero
   function automatic logic [3:0] read_image(input logic [7:0] a,
                                             input special_output_pkg::port_state_t st);
      read_image = 4'h0;
      if (a == special_output_pkg::OUTPUT_PORT_CONTROL_ADDR)
      begin
         read_image[special_output_pkg::OUT_PIN_ONE_BIT:0] = st.out_port;
      end
      else if (a == special_output_pkg::TONE_FREQUENCY_SELECT_ADDR)
      begin
         read_image[special_output_pkg::TONE_PITCH_BIT] = st.tone_pitch_select;
         read_image[special_output_pkg::DIVCLK_SELECT_HI_BIT:0] = st.divclk_select;
      end
   endfunction

   // Write strobe aimed at one register
   function automatic logic wr_hit(input special_output_pkg::io_req_t r,
                                   input logic [7:0]                  a);
      wr_hit = r.wr && (r.addr == a);
   endfunction

   tone_divider u_div
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .o_taps     (taps)
   );

   assign req = '{addr: i_addr, wr: i_wr, rd: i_rd, wdata: i_wdata};

   always_comb
   begin
      s_d = s_q;
      // Pitch bit picks the slower tone when set
      tone = s_q.tone_pitch_select ? taps[special_output_pkg::TONE_TAP_2K]
                                   : taps[special_output_pkg::TONE_TAP_4K];
      divclk = taps[divclk_tap(s_q.divclk_select)];
      if (wr_hit(req, special_output_pkg::OUTPUT_PORT_CONTROL_ADDR))
      begin
         s_d.out_port = req.wdata[special_output_pkg::OUT_PIN_ONE_BIT:0];
      end
      if (wr_hit(req, special_output_pkg::TONE_FREQUENCY_SELECT_ADDR))
      begin
         s_d.tone_pitch_select = req.wdata[special_output_pkg::TONE_PITCH_BIT];
         s_d.divclk_select = req.wdata[special_output_pkg::DIVCLK_SELECT_HI_BIT:0];
      end
      s_d.rdata = req.rd ? read_image(req.addr, s_q) : 4'h0;
      // Second pin: register level or gated buzzer, low while off
      if (PIN1_SPECIAL)
      begin
         s_d.out_pin_one = s_q.out_port[special_output_pkg::OUT_PIN_ONE_BIT] & tone;
      end
      else
      begin
         s_d.out_pin_one = s_q.out_port[special_output_pkg::OUT_PIN_ONE_BIT];
      end
      // First pin by its build-time function
      case (PIN0_MODE)
         special_output_pkg::PIN0_DIVCLK:
            s_d.out_pin_zero = s_q.out_port[special_output_pkg::OUT_PIN_ZERO_BIT]
                               & divclk;
         special_output_pkg::PIN0_TONE_INV:
            s_d.out_pin_zero = s_q.out_port[special_output_pkg::OUT_PIN_ONE_BIT]
                               & ~tone;
         special_output_pkg::PIN0_PLAIN:
            s_d.out_pin_zero = s_q.out_port[special_output_pkg::OUT_PIN_ZERO_BIT];
         default:
            s_d.out_pin_zero = special_output_pkg::PIN_RESET;
      endcase
   end

   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         s_q.out_port          <= special_output_pkg::OUT_PORT_RESET;
         s_q.tone_pitch_select <= special_output_pkg::TONE_PITCH_RESET;
         s_q.divclk_select     <= special_output_pkg::DIVCLK_SEL_RESET;
         s_q.rdata             <= special_output_pkg::READ_DATA_RESET;
         s_q.out_pin_zero      <= special_output_pkg::PIN_RESET;
         s_q.out_pin_one       <= special_output_pkg::PIN_RESET;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign o_rdata        = s_q.rdata;
   assign o_out_pin_zero = s_q.out_pin_zero;
   assign o_out_pin_one  = s_q.out_pin_one;

endmodule

`default_nettype wire

/* tb/tone_listener.sv */
// Piezo stand-in: times the high phase of one wave pin.
// Assumes a square wave; counts core clock cycles.
`timescale 1ns/1ps
`default_nettype none
module tone_listener
(
   input  wire logic        i_core_clk, // Clock
   input  wire logic        i_pin,      // Wave pin
   output logic      [31:0] o_high_len = 32'h0, // Last high phase
   output logic      [31:0] o_falls = 32'h0     // Falls seen
);
   logic [31:0] run_q = 32'h0;
   logic        pin_q = 1'h0;
   always @(posedge i_core_clk)
   begin
      pin_q <= i_pin;
      if (i_pin)
         run_q <= run_q + 32'h1;
      else if (pin_q)
      begin
         o_high_len <= run_q;
         o_falls <= o_falls + 32'h1;
         run_q <= 32'h0;
      end
   end
endmodule
`default_nettype wire

/* tb/special_output_port_properties.sv */
// Checks on register reads and pin levels.
// Assumes bind to each port build; shadow copy tracks writes.
`timescale 1ns/1ps
`default_nettype none
module sop_properties
#(
   parameter logic                           PIN1_SPECIAL = 1'h0,
   parameter special_output_pkg::pin0_mode_t PIN0_MODE    = special_output_pkg::PIN0_PLAIN
)
(
   input wire logic       i_core_clk,     // Clock
   input wire logic       i_rst_n,        // Reset
   input wire logic [7:0] i_addr,         // Address
   input wire logic       i_wr,           // Write
   input wire logic       i_rd,           // Read
   input wire logic [3:0] i_wdata,        // Data in
   input wire logic [3:0] o_rdata,        // Data out
   input wire logic       o_out_pin_zero, // Pin 0
   input wire logic       o_out_pin_one   // Pin 1
);
   localparam logic [7:0] PA = special_output_pkg::OUTPUT_PORT_CONTROL_ADDR;
   localparam logic [7:0] TA = special_output_pkg::TONE_FREQUENCY_SELECT_ADDR;
   logic [4:0] sh_q;
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   always_ff @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         sh_q <= 5'h00;
      else if (i_wr && i_addr == PA)
         sh_q[1:0] <= i_wdata[1:0];
      else if (i_wr && i_addr == TA)
         sh_q[4:2] <= {i_wdata[3], i_wdata[1:0]};
   end
   sequence read_s(a); i_rd && i_addr == a; endsequence
   rd_idle_a: assert property (!i_rd |=> o_rdata == 4'h0) else $error("rdata not idle");
   rd_port_a: assert property (read_s(PA) |=> o_rdata == {2'h0, $past(sh_q[1:0])})
      else $error("port readback wrong");
   rd_tone_a: assert property (read_s(TA) |=>
      o_rdata == {$past(sh_q[4]), 1'h0, $past(sh_q[3:2])}) else $error("tone readback wrong");
   rd_unmap_a: assert property (i_rd && i_addr != PA && i_addr != TA |=> o_rdata == 4'h0)
      else $error("unmapped read not zero");
   plain_one_a: assert property (!PIN1_SPECIAL && $past(i_rst_n)
      |-> o_out_pin_one == $past(sh_q[1])) else $error("plain pin one wrong");
   plain_zero_a: assert property (PIN0_MODE == special_output_pkg::PIN0_PLAIN
      && $past(i_rst_n) |-> o_out_pin_zero == $past(sh_q[0]))
      else $error("plain pin zero wrong");
   tone_off_a: assert property (PIN1_SPECIAL && !$past(sh_q[1]) |-> !o_out_pin_one)
      else $error("buzzer pin not low");
   divclk_off_a: assert property (PIN0_MODE == special_output_pkg::PIN0_DIVCLK
      && !$past(sh_q[0]) |-> !o_out_pin_zero) else $error("divided clock pin not low");
   inv_pair_a: assert property (PIN0_MODE == special_output_pkg::PIN0_TONE_INV
      && PIN1_SPECIAL && $past(i_rst_n)
      |-> o_out_pin_zero == ($past(sh_q[1]) && !o_out_pin_one)) else $error("inverse pin wrong");
   reset_clear_a: assert property (disable iff (1'h0) !i_rst_n |=> o_rdata == 4'h0 &&
      !o_out_pin_zero && !o_out_pin_one) else $error("reset not clearing");
endmodule
`default_nettype wire

/* tb/test_special_output_port.sv */
// Bench: register access, plain pins, wave timing.
// Assumes three port builds share one bus; listeners time waves.
`timescale 1ns/1ps
`default_nettype none
module test_special_output_port;
   logic        clk = 1'h0;
   logic        rst_n = 1'h0;
   logic [7:0]  addr = 8'h00;
   logic        wr = 1'h0;
   logic        rd = 1'h0;
   logic [3:0]  wdata = 4'h0;
   logic [3:0]  rdata;
   logic [1:0]  p;
   logic [1:0]  q;
   logic [1:0]  r;
   logic [31:0] len0;
   logic [31:0] len1;
   logic [31:0] f0;
   logic [31:0] f1;
   int          fails = 0;
   int          n_checks = 0;
   always #12.5 clk = ~clk;
   special_output_port #(.PIN1_SPECIAL(1'h1), .PIN0_MODE(special_output_pkg::PIN0_DIVCLK),
      .DIV_SET(5)) u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr),
      .i_rd(rd), .i_wdata(wdata), .o_rdata(rdata), .o_out_pin_zero(p[0]), .o_out_pin_one(p[1]));
   special_output_port u_plain (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr),
      .i_rd(rd), .i_wdata(wdata), .o_rdata(), .o_out_pin_zero(q[0]), .o_out_pin_one(q[1]));
   special_output_port #(.PIN1_SPECIAL(1'h1), .PIN0_MODE(special_output_pkg::PIN0_TONE_INV))
      u_inv (.i_core_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wr(wr), .i_rd(rd),
      .i_wdata(wdata), .o_rdata(), .o_out_pin_zero(r[0]), .o_out_pin_one(r[1]));
   tone_listener u_l0 (.i_core_clk(clk), .i_pin(p[0]), .o_high_len(len0), .o_falls(f0));
   tone_listener u_l1 (.i_core_clk(clk), .i_pin(p[1]), .o_high_len(len1), .o_falls(f1));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("BAD t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [3:0] d);
      addr = a;
      wdata = d;
      wr = 1'h1;
      @(negedge clk);
      wr = 1'h0;
      // Let one edge pass low so a following call never re-raises the strobe at once
      @(negedge clk);
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [3:0] e);
      addr = a;
      rd = 1'h1;
      @(negedge clk);
      rd = 1'h0;
      chk(32'(rdata), 32'(e));
      @(negedge clk);
   endtask
   // Two fresh falls so the timed phase began after the new setting
   task automatic wait_falls(input int n1);
      logic [31:0] b0;
      logic [31:0] b1;
      int          t;
      b0 = f0;
      b1 = f1;
      t = 0;
      while ((f0 < b0 + 2 || f1 < b1 + n1) && t < 50000)
      begin
         @(negedge clk);
         t++;
      end
      if (t == 50000)
      begin
         fails++;
         give_verdict;
      end
   endtask
   // Half period in core cycles of fosc/2^m; three cycles of edge jitter allowed
   function automatic int half(input int m);
      return int'((special_output_pkg::CORE_CLK_HZ << m) / (2 * special_output_pkg::FOSC_HZ));
   endfunction
   function automatic logic [31:0] near(input logic [31:0] s, input int e);
      return (s + 3 >= e && s <= e + 3) ? 32'(e) : s;
   endfunction
   initial
   begin
      repeat (5) @(negedge clk);
      rst_n = 1'h1;
      reg_rd(8'hF3, 4'h0);
      reg_rd(8'hFD, 4'h0);
      reg_wr(8'hFD, 4'hF);
      reg_rd(8'hFD, 4'hB);
      reg_wr(8'hF4, 4'hF);
      reg_rd(8'hF4, 4'h0);
      for (int v = 0; v < 4; v++)
      begin
         reg_wr(8'hF3, 4'(v) | 4'hC);
         reg_rd(8'hF3, 4'(v));
         chk(32'(q), 32'(v));
      end
      for (int s = 0; s < 4; s++)
      begin
         reg_wr(8'hFD, {s == 3, 1'h0, 2'(s)});
         reg_wr(8'hF3, 4'h3);
         wait_falls((s == 0 || s == 3) ? 2 : 0);
         chk(near(len0, half(3 - s)), 32'(half(3 - s)));
         if (s == 0 || s == 3)
            chk(near(len1, half(s / 3 + 3)), 32'(half(s / 3 + 3)));
         chk(32'(r[0] ^ r[1]), 32'h1);
      end
      reg_wr(8'hF3, 4'h0);
      repeat (2) @(negedge clk);
      chk(32'(p), 32'h0);
      chk(32'(r), 32'h0);
      // Mid-run reset with both registers and the plain pins non-zero
      reg_wr(8'hF3, 4'h3);
      chk(32'(q), 32'h3);
      rst_n = 1'h0;
      @(negedge clk);
      rst_n = 1'h1;
      reg_rd(8'hF3, 4'h0);
      reg_rd(8'hFD, 4'h0);
      chk(32'(q), 32'h0);
      give_verdict;
   end
endmodule
bind special_output_port sop_properties #(.PIN1_SPECIAL(PIN1_SPECIAL), .PIN0_MODE(PIN0_MODE))
   u_props (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr(i_wr),
   .i_rd(i_rd), .i_wdata(i_wdata), .o_rdata(o_rdata), .o_out_pin_zero(o_out_pin_zero),
   .o_out_pin_one(o_out_pin_one));
`default_nettype wire
